// ### rtl/adcc_sequencer.sv
// file: conversion sequencer with its register file
`timescale 1ns/100ps
`default_nettype none
module adcc_sequencer
#(
  parameter int SAMPLE_N = adcc_pkg::SAMPLE_PERIODS,
  parameter int CONV_N   = adcc_pkg::CONV_PERIODS
)
(
  // clock and reset (clk_i is the oscillator clock)
  input  wire logic                  clk_i,
  input  wire logic                  nrst_i,
  // register port
  input  wire logic [adcc_pkg::AW-1:0] addr_i,
  input  wire logic [adcc_pkg::DW-1:0] wdata_i,
  input  wire logic                  wr_i,
  input  wire logic                  rd_i,
  output logic [adcc_pkg::DW-1:0]    rdata_o,
  // analog core
  input  wire logic [adcc_pkg::RES_W-1:0] sar_value_i,
  output adcc_pkg::adcc_phase_s      phase_o,
  output logic                       sample_tick_o,
  output logic                       conv_tick_o,
  // status and interrupt
  output logic                       busy_o,
  output logic                       irq_o
);
  import adcc_pkg::*;

  // elaboration checks: phase counters are eight bits wide
  if (SAMPLE_N < 1 || SAMPLE_N > 255)
  begin : g_bad_samp
    $error("adcc_sequencer: SAMPLE_N out of range");
  end
  if (CONV_N < 1 || CONV_N > 255)
  begin : g_bad_conv
    $error("adcc_sequencer: CONV_N out of range");
  end

  localparam logic [7:0] SAMP_LAST = 8'(SAMPLE_N - 1);
  localparam logic [7:0] CONV_LAST = 8'(CONV_N - 1);

  // software-visible state
  logic          cont_r;        // continuous_mode_bit
  logic          cont_nxt;
  adcc_clk_cfg_s cfg_r;         // prescaler selections
  adcc_clk_cfg_s cfg_nxt;
  logic          done_r;        // conv_done_irq_flag
  logic          done_nxt;
  logic          irq_en_r;      // conv_irq_enable
  logic          irq_en_nxt;
  logic [RES_W-1:0] res_r;      // stored result
  logic [RES_W-1:0] res_nxt;
  logic          ran_r;         // a conversion happened since reset
  logic          ran_nxt;

  // sequencer state
  adcc_state_e   st_r;
  adcc_state_e   st_nxt;
  logic [2:0]    mc_r;          // position in machine cycle
  logic [2:0]    mc_nxt;
  logic [7:0]    per_r;         // prescaled periods in phase
  logic [7:0]    per_nxt;
  logic          busy_nxt;
  adcc_phase_s   phase_nxt;

  // bus outputs
  logic [DW-1:0] rdata_nxt;
  logic          irq_nxt;

  // decoded accesses
  logic          wr_lo;
  logic          wr_a;
  logic          mc_end;
  logic          restart_ps;
  logic [5:0]    conv_div;
  logic [5:0]    samp_div;
  logic          samp_tick;
  logic          conv_tick;

  assign wr_lo  = wr_i && (addr_i == IDX_RES_LO);
  assign wr_a   = wr_i && (addr_i == IDX_CTRL_A);
  assign mc_end = (mc_r == MC_LAST);

  // conversion clock ratio lookup
  always_comb
  begin
    unique case (cfg_r.conv_sel)
      2'h0: conv_div = DIV_4;
      2'h1: conv_div = DIV_8;
      2'h2: conv_div = DIV_16;
      2'h3: conv_div = DIV_32;
    endcase
  end

  // sample clock ratio lookup
  always_comb
  begin
    unique case (cfg_r.samp_sel)
      2'h0: samp_div = DIV_2;
      2'h1: samp_div = DIV_8;
      2'h2: samp_div = DIV_16;
      2'h3: samp_div = DIV_32;
    endcase
  end

  // prescalers restart whenever a phase begins so that each
  // phase spans whole prescaled periods of the input clock
  assign restart_ps = (st_nxt != st_r) || wr_lo;

  adcc_prescaler #(
    .DIV_W (6)
  ) u_samp_ps (
    .clk_i     (clk_i),
    .nrst_i    (nrst_i),
    .restart_i (restart_ps),
    .div_i     (samp_div),
    .tick_o    (samp_tick)
  );

  adcc_prescaler #(
    .DIV_W (6)
  ) u_conv_ps (
    .clk_i     (clk_i),
    .nrst_i    (nrst_i),
    .restart_i (restart_ps),
    .div_i     (conv_div),
    .tick_o    (conv_tick)
  );

  // machine cycle counter, free running from reset
  always_comb
  begin
    mc_nxt = mc_end ? 3'h0 : mc_r + 3'h1;
  end

  // sequencer next state
  always_comb
  begin
    st_nxt    = st_r;
    per_nxt   = per_r;
    busy_nxt  = busy_o;
    ran_nxt   = ran_r;
    res_nxt   = res_r;
    phase_nxt = '0;
    unique case (st_r)
      ST_IDLE:
      begin
        // idle until started by software
        if (cont_nxt && !cont_r && ran_r)
          st_nxt = ST_ARM;
      end
      ST_ARM:
      begin
        // wait for the next machine cycle boundary
        if (mc_end)
        begin
          st_nxt   = ST_SAMP;
          busy_nxt = 1'b1;
          per_nxt  = '0;
        end
      end
      ST_SAMP:
      begin
        phase_nxt.sample = 1'b1;
        if (samp_tick)
        begin
          per_nxt = per_r + 8'h01;
          if (per_r == SAMP_LAST)
          begin
            st_nxt  = ST_CONV;
            per_nxt = '0;
          end
        end
      end
      ST_CONV:
      begin
        phase_nxt.convert = 1'b1;
        if (conv_tick)
        begin
          per_nxt = per_r + 8'h01;
          if (per_r == CONV_LAST)
            st_nxt = ST_ALIGN;
        end
      end
      ST_ALIGN:
      begin
        // total time ends with the machine cycle in progress;
        // the write cycle is not part of it
        phase_nxt.convert = !mc_end;
        if (mc_end)
        begin
          st_nxt   = ST_WRITE;
          busy_nxt = 1'b0;
          res_nxt  = sar_value_i;
          ran_nxt  = 1'b1;
        end
      end
      ST_WRITE:
      begin
        // one machine cycle in which the result is readable
        if (mc_end)
        begin
          if (cont_r)
          begin
            st_nxt   = ST_SAMP;
            busy_nxt = 1'b1;
            per_nxt  = '0;
          end
          else
          begin
            st_nxt = ST_IDLE;
          end
        end
      end
      default:
      begin
        st_nxt   = ST_IDLE;
        busy_nxt = 1'b0;
      end
    endcase
    // a dummy write wins over every state transition, but not the result capture: abandon and rearm
    if (wr_lo)
    begin
      st_nxt    = ST_ARM;
      busy_nxt  = busy_o;   // held until the new first cycle
      phase_nxt = '0;
      per_nxt   = '0;
    end
  end

  // software registers next values
  always_comb
  begin
    cont_nxt   = cont_r;
    cfg_nxt    = cfg_r;
    irq_en_nxt = irq_en_r;
    done_nxt   = done_r;
    if (wr_a)
      cont_nxt = wdata_i[POS_CONT_MODE];
    if (wr_i && addr_i == IDX_CTRL_B)
    begin
      cfg_nxt.conv_sel = wdata_i[POS_CONV_SEL +: 2];
      cfg_nxt.samp_sel = wdata_i[POS_SAMP_SEL +: 2];
    end
    if (wr_i && addr_i == IDX_IRQ_EN)
      irq_en_nxt = wdata_i[POS_IRQ_EN];
    // software write is the only clear
    if (wr_i && addr_i == IDX_IRQ_REQ)
      done_nxt = wdata_i[POS_DONE];
    // set at end of conversion wins over a clear
    if (st_r == ST_ALIGN && mc_end && !wr_lo)
      done_nxt = 1'b1;
  end

  // interrupt request: flag gated by enable
  always_comb
  begin
    irq_nxt = done_nxt && irq_en_nxt;
  end

  // read data, valid only in the cycle after the strobe;
  // the dummy value written to result_low is never stored
  always_comb
  begin
    rdata_nxt = '0;
    if (rd_i)
    begin
      unique case (addr_i)
        IDX_CTRL_A:
        begin
          rdata_nxt[POS_CONT_MODE] = cont_r;
          rdata_nxt[POS_ACTIVE]    = busy_o;
        end
        IDX_CTRL_B:
        begin
          rdata_nxt[POS_CONV_SEL +: 2] = cfg_r.conv_sel;
          rdata_nxt[POS_SAMP_SEL +: 2] = cfg_r.samp_sel;
          // hint for software: ratio too small for the clock
          rdata_nxt[POS_TOO_FAST] = (conv_div < CONV_MIN_DIV);
        end
        IDX_RES_LO:
          rdata_nxt[POS_RES_LO +: 2] = res_r[1:0];
        IDX_RES_HI:
          rdata_nxt = res_r[RES_W-1:2];
        IDX_IRQ_REQ:
          rdata_nxt[POS_DONE] = done_r;
        IDX_IRQ_EN:
          rdata_nxt[POS_IRQ_EN] = irq_en_r;
        default:
          rdata_nxt = '0;  // unmapped reads zero
      endcase
    end
  end

  // registers of the sequencer
  always_ff @(posedge clk_i)
  begin
    if (!nrst_i)
    begin
      st_r    <= ST_IDLE;
      mc_r    <= 3'h0;
      per_r   <= 8'h00;
      busy_o  <= 1'b0;
      ran_r   <= 1'b0;
      res_r   <= '0;
      phase_o <= '0;
    end
    else
    begin
      st_r    <= st_nxt;
      mc_r    <= mc_nxt;
      per_r   <= per_nxt;
      busy_o  <= busy_nxt;
      ran_r   <= ran_nxt;
      res_r   <= res_nxt;
      phase_o <= phase_nxt;
    end
  end

  // registers seen by software
  always_ff @(posedge clk_i)
  begin
    if (!nrst_i)
    begin
      cont_r        <= 1'b0;
      cfg_r         <= '{samp_sel: SAMP_SEL_RST,
                         conv_sel: CONV_SEL_RST};
      done_r        <= 1'b0;
      irq_en_r      <= 1'b0;
      irq_o         <= 1'b0;
      rdata_o       <= '0;
      sample_tick_o <= 1'b0;
      conv_tick_o   <= 1'b0;
    end
    else
    begin
      cont_r        <= cont_nxt;
      cfg_r         <= cfg_nxt;
      done_r        <= done_nxt;
      irq_en_r      <= irq_en_nxt;
      irq_o         <= irq_nxt;
      rdata_o       <= rdata_nxt;
      sample_tick_o <= samp_tick;
      conv_tick_o   <= conv_tick;
    end
  end

endmodule : adcc_sequencer
`default_nettype wire

// ### rtl/adcc_pkg.sv
// package: constants, register map and types of the conversion sequencer
// Behaviour
// - sample clock divides by 2, 8, 16, 32
// - conversion clock code 11 divides by 32
// - conversion clock codes 00/01/10: 4, 8, 16
// - all clocks prescaled from the system clock
// - conversions last whole input clock periods
// - dummy write to low result starts conversion
// - such write restarts a running conversion
// - start next machine cycle, set busy flag
// - phases: sample, convert, write result
// - total time is sample plus convert, up to the end of that machine cycle
// - three ways continuous conversion is started
// - clearing continuous bit ends after current one
// - continuous restart after write-result cycle
// - busy set at start, cleared at write
// - done flag set by hardware, software clears
// - enable low blocks the interrupt request
// - 10-bit result split over two registers
package adcc_pkg;

  // register bus shape
  localparam int DW = 8;
  localparam int AW = 3;

  // register indices
  localparam logic [AW-1:0] IDX_CTRL_A  = 3'h0; // converter_ctrl_reg_a
  localparam logic [AW-1:0] IDX_CTRL_B  = 3'h1; // converter_ctrl_reg_b
  localparam logic [AW-1:0] IDX_RES_LO  = 3'h2; // result_low_reg
  localparam logic [AW-1:0] IDX_RES_HI  = 3'h3; // result_high_reg
  localparam logic [AW-1:0] IDX_IRQ_REQ = 3'h4; // irq_request_reg
  localparam logic [AW-1:0] IDX_IRQ_EN  = 3'h5; // irq_enable_reg_b

  // field positions
  localparam int POS_CONT_MODE = 0; // ctrl_a: continuous_mode_bit
  localparam int POS_ACTIVE    = 1; // ctrl_a: conversion_active_flag
  localparam int POS_CONV_SEL  = 0; // ctrl_b: conv clock select [1:0]
  localparam int POS_SAMP_SEL  = 2; // ctrl_b: sample clock select [3:2]
  localparam int POS_TOO_FAST  = 7; // ctrl_b: conv clock above limit
  localparam int POS_DONE      = 0; // irq_request: conv_done_irq_flag
  localparam int POS_IRQ_EN    = 0; // irq_enable: conv_irq_enable
  localparam int POS_RES_LO    = 6; // result_low holds result[1:0]

  // values after reset
  localparam logic [1:0] CONV_SEL_RST = 2'h1;
  localparam logic [1:0] SAMP_SEL_RST = 2'h0;

  // divide ratios in input clock periods
  localparam logic [5:0] DIV_2  = 6'h02;
  localparam logic [5:0] DIV_4  = 6'h04;
  localparam logic [5:0] DIV_8  = 6'h08;
  localparam logic [5:0] DIV_16 = 6'h10;
  localparam logic [5:0] DIV_32 = 6'h20;

  // timing: one machine cycle is six input clock periods
  localparam int         MC_CLKS = 6;
  localparam logic [2:0] MC_LAST = 3'(MC_CLKS - 1);
  localparam int         CLK_MHZ      = 40;
  localparam int         CONV_MAX_MHZ = 2;
  localparam logic [5:0] CONV_MIN_DIV = 6'(CLK_MHZ / CONV_MAX_MHZ);

  // phase lengths in prescaled clock periods (defaults)
  localparam int SAMPLE_PERIODS = 4;
  localparam int CONV_PERIODS   = 12;
  localparam int RES_W          = 10;

  // sequencer states
  typedef enum logic [2:0] {
    ST_IDLE  = 3'h0,
    ST_ARM   = 3'h1,
    ST_SAMP  = 3'h2,
    ST_CONV  = 3'h3,
    ST_ALIGN = 3'h4,
    ST_WRITE = 3'h5
  } adcc_state_e;

  // prescaler selections of converter_ctrl_reg_b
  typedef struct packed {
    logic [1:0] samp_sel;
    logic [1:0] conv_sel;
  } adcc_clk_cfg_s;

  // phase indication toward the analog core
  typedef struct packed {
    logic sample;
    logic convert;
  } adcc_phase_s;

endpackage : adcc_pkg

// ### rtl/adcc_prescaler.sv
// file: restartable clock prescaler giving a one-cycle tick
`timescale 1ns/100ps
`default_nettype none
module adcc_prescaler
#(
  parameter int DIV_W = 6
)
(
  // clock and reset
  input  wire logic             clk_i,
  input  wire logic             nrst_i,
  // control
  input  wire logic             restart_i,
  input  wire logic [DIV_W-1:0] div_i,
  // output
  output logic                  tick_o
);
  import adcc_pkg::*;

  // elaboration check: a one-bit counter cannot hold a ratio
  if (DIV_W < 2)
  begin : g_bad_width
    $error("adcc_prescaler: DIV_W too small");
  end

  logic [DIV_W-1:0] cnt_r;   // input clocks in current period
  logic [DIV_W-1:0] cnt_nxt;
  logic             tick_nxt;

  // count whole input clock periods; restart aligns the phase
  always_comb
  begin
    cnt_nxt  = cnt_r + 1'b1;
    tick_nxt = 1'b0;
    if (restart_i)
    begin
      cnt_nxt = '0;
    end
    else if (cnt_r >= div_i - 1'b1)
    begin
      cnt_nxt  = '0;
      tick_nxt = 1'b1;
    end
  end

  // registers only
  always_ff @(posedge clk_i)
  begin
    if (!nrst_i)
    begin
      cnt_r  <= '0;
      tick_o <= 1'b0;
    end
    else
    begin
      cnt_r  <= cnt_nxt;
      tick_o <= tick_nxt;
    end
  end

endmodule : adcc_prescaler
`default_nettype wire

// ### test/adcc_checker.sv
// checker: port-level assertions for the conversion sequencer
`timescale 1ns/100ps
`default_nettype none
module adcc_checker
  import adcc_pkg::*;
(
  // clock and reset
  input wire logic          clk_i,
  input wire logic          nrst_i,
  // register port
  input wire logic [AW-1:0] addr_i,
  input wire logic [DW-1:0] wdata_i,
  input wire logic          wr_i,
  input wire logic          rd_i,
  input wire logic [DW-1:0] rdata_o,
  // status
  input wire logic          busy_o,
  input wire logic          irq_o
);
  logic [7:0] bcnt_r, bcnt_nxt; // cycles busy has stood so far
  logic       cont_r, cont_nxt; // shadow of the continuous bit
  logic       en_r, en_nxt;     // shadow of the interrupt enable
  logic [1:0] clr_r, clr_nxt;   // recent writes able to drop irq
  logic       wr_lo;            // start or restart request
  logic       wr_irq;           // write to flag or enable

  // shadows follow the bus, so no body signal is needed
  always_comb
  begin
    wr_lo    = wr_i && addr_i == IDX_RES_LO;
    wr_irq   = wr_i && (addr_i == IDX_IRQ_REQ || addr_i == IDX_IRQ_EN);
    bcnt_nxt = busy_o ? bcnt_r + 8'h01 : 8'h00;
    cont_nxt = (wr_i && addr_i == IDX_CTRL_A) ? wdata_i[0] : cont_r;
    en_nxt   = (wr_i && addr_i == IDX_IRQ_EN) ? wdata_i[0] : en_r;
    clr_nxt  = {clr_r[0], wr_irq};
  end

  // registers only
  always_ff @(posedge clk_i)
  begin
    if (!nrst_i)
    begin
      bcnt_r <= 8'h00;
      cont_r <= 1'b0;
      en_r   <= 1'b0;
      clr_r  <= 2'h0;
    end
    else
    begin
      bcnt_r <= bcnt_nxt;
      cont_r <= cont_nxt;
      en_r   <= en_nxt;
      clr_r  <= clr_nxt;
    end
  end

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!nrst_i);

  // write-result cycle of one machine cycle, then busy again
  sequence write_gap;
    !busy_o[*4] ##[1:3] busy_o;
  endsequence
  // a restart never lets busy drop in between
  sequence held_six;
    busy_o[*6];
  endsequence

  start_busy_a: assert property
    (wr_lo && !busy_o |-> ##[1:8] busy_o)
    else $error("busy did not rise after a start write");
  restart_hold_a: assert property
    (busy_o && wr_lo |=> held_six)
    else $error("busy dropped after a restart write");
  whole_cycles_a: assert property
    ($fell(busy_o) |-> bcnt_r % 8'h06 == 8'h00)
    else $error("busy length is not whole machine cycles");
  cont_restart_a: assert property
    ($fell(busy_o) && cont_r |-> write_gap)
    else $error("continuous restart not one machine cycle later");
  single_stop_a: assert property
    ($fell(busy_o) && !cont_r |-> !busy_o[*8])
    else $error("conversion restarted without continuous mode");
  irq_gate_a: assert property
    (irq_o |-> en_r)
    else $error("interrupt raised while disabled");
  irq_raise_a: assert property
    ($fell(busy_o) && en_r |-> ##[0:2] irq_o)
    else $error("interrupt missing after conversion end");
  irq_sticky_a: assert property
    ($fell(irq_o) |-> clr_r != 2'h0)
    else $error("interrupt dropped without a software write");
  rdata_idle_a: assert property
    (!$past(rd_i) |-> rdata_o == 8'h00)
    else $error("read data outside its cycle");
endmodule : adcc_checker
`default_nettype wire

bind adcc_sequencer adcc_checker u_chk (
  .clk_i(clk_i), .nrst_i(nrst_i), .addr_i(addr_i), .wdata_i(wdata_i),
  .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .busy_o(busy_o),
  .irq_o(irq_o));

// ### test/adcc_sequencer_tb.sv
// testbench: register-level tests of the conversion sequencer
`timescale 1ns/100ps
`default_nettype none
module adcc_sequencer_tb;
  import adcc_pkg::*;
  // expected ratios by selector code
  localparam logic [5:0] SDIV [4] = '{DIV_2, DIV_8, DIV_16, DIV_32};
  localparam logic [5:0] CDIV [4] = '{DIV_4, DIV_8, DIV_16, DIV_32};
  logic              clk_i   = 1'b0;
  logic              nrst_i  = 1'b0;
  logic [AW-1:0]     addr_i  = '0;
  logic [DW-1:0]     wdata_i = '0;
  logic              wr_i    = 1'b0;
  logic              rd_i    = 1'b0;
  logic [RES_W-1:0]  sar_value_i = '0;
  logic [DW-1:0]     rdata_o;
  adcc_phase_s       phase_o;
  logic              sample_tick_o;
  logic              conv_tick_o;
  logic              busy_o;
  logic              irq_o;
  int                bad_count   = 0;
  int                comparisons = 0;
  wire logic [1:0]   tks = {conv_tick_o, sample_tick_o};
  wire logic [1:0]   phs = {phase_o.convert, phase_o.sample};

  // short phases keep the divide-by-32 runs brief
  adcc_sequencer #(.SAMPLE_N(2), .CONV_N(2)) u_dut (
    .clk_i(clk_i), .nrst_i(nrst_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .sar_value_i(sar_value_i), .phase_o(phase_o),
    .sample_tick_o(sample_tick_o), .conv_tick_o(conv_tick_o),
    .busy_o(busy_o), .irq_o(irq_o));

  // 40 MHz clock
  always #12.5 clk_i = ~clk_i;

  // verdict and end of run
  task tally_and_finish;
    $display("checks %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : tally_and_finish

  // one edge, then settle
  task cyc;
    @(posedge clk_i);
    #1;
  endtask : cyc

  task lost;
    bad_count++;
    tally_and_finish;
  endtask : lost

  task chk(input logic [9:0] s, input logic [9:0] e);
    comparisons++;
    if (s !== e)
    begin
      $display("Error at %0t: seen %h expected %h", $time, s, e);
      bad_count++;
    end
  endtask : chk

  // single-cycle write strobe
  task wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
    @(posedge clk_i);
    addr_i  <= a;
    wdata_i <= d;
    wr_i    <= 1'b1;
    @(posedge clk_i);
    wr_i    <= 1'b0;
  endtask : wr

  // data stand only in the cycle after the strobe
  task rd(input logic [AW-1:0] a, input logic [DW-1:0] e);
    @(posedge clk_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge clk_i);
    rd_i   <= 1'b0;
    #1;
    chk(10'(rdata_o), 10'(e));
  endtask : rd

  task wait_b(input logic v);
    int i;
    cyc;
    for (i = 0; i < 600 && busy_o !== v; i++)
      cyc;
    if (i >= 600)
      lost;
  endtask : wait_b

  // spacing of two ticks inside a fresh phase (c: 0 sample, 1 conv)
  task gap(input logic c, input logic [5:0] d);
    int i;
    int n;
    cyc;
    for (i = 0; i < 300 && !c && phs[0] === 1'b1; i++)
      cyc;
    if (i >= 300)
      lost;
    for (i = 0; i < 300 && phs[c] !== 1'b1; i++)
      cyc;
    if (i >= 300)
      lost;
    for (i = 0; i < 300 && tks[c] !== 1'b1; i++)
      cyc;
    if (i >= 300)
      lost;
    cyc;
    for (n = 1; n < 300 && tks[c] !== 1'b1; n++)
      cyc;
    chk(10'(n), 10'(d));
    if (n >= 300)
      lost;
  endtask : gap

  // clear continuous mode mid-conversion and see it stop
  task stop;
    wr(IDX_CTRL_A, 8'h00);
    wait_b(1'b0);
    repeat (30) cyc;
    chk(10'(busy_o), 10'h000);
  endtask : stop

  initial
  begin
    logic [1:0] c;
    repeat (10) @(posedge clk_i);
    nrst_i <= 1'b1;
    rd(IDX_CTRL_A, 8'h00);
    rd(IDX_CTRL_B, 8'h81);
    rd(IDX_IRQ_REQ, 8'h00);
    wr(3'h6, 8'hff);
    rd(3'h6, 8'h00);
    // continuous bit before any conversion only arms
    wr(IDX_CTRL_A, 8'h03);
    repeat (20) cyc;
    chk(10'(busy_o), 10'h000);
    wr(IDX_RES_LO, 8'h3c);
    wait_b(1'b1);
    wait_b(1'b0);
    wait_b(1'b1);
    rd(IDX_CTRL_A, 8'h03);
    stop;
    for (int k = 0; k < 4; k++)
    begin
      c = k[1:0];
      wr(IDX_IRQ_EN, {7'h00, c[1]});
      sar_value_i <= {c, c, 6'h2d};
      wr(IDX_CTRL_B, {4'h0, c, c});
      rd(IDX_CTRL_B, {c != 2'h3, 3'h0, c, c});
      wr(IDX_RES_LO, 8'ha5);
      wait_b(1'b1);
      rd(IDX_CTRL_A, 8'h02);
      wr(IDX_RES_LO, 8'h00);
      gap(1'b0, SDIV[c]);
      gap(1'b1, CDIV[c]);
      wait_b(1'b0);
      rd(IDX_RES_HI, {c, c, 4'hb});
      rd(IDX_RES_LO, 8'h40);
      rd(IDX_IRQ_REQ, 8'h01);
      chk(10'(irq_o), 10'(c[1]));
      wr(IDX_IRQ_REQ, 8'h00);
      repeat (3) cyc;
      chk(10'(irq_o), 10'h000);
    end
    // continuous bit after earlier conversions starts at once
    wr(IDX_CTRL_B, 8'h00);
    wr(IDX_CTRL_A, 8'h01);
    wait_b(1'b1);
    rd(IDX_CTRL_A, 8'h03);
    stop;
    // continuous bit set during a running single conversion
    wr(IDX_RES_LO, 8'h00);
    wait_b(1'b1);
    wr(IDX_CTRL_A, 8'h01);
    wait_b(1'b0);
    wait_b(1'b1);
    rd(IDX_CTRL_A, 8'h03);
    stop;
    tally_and_finish;
  end
endmodule : adcc_sequencer_tb
`default_nettype wire
